// ### src/saru_regs.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 security alarm response unit.
 Assumes inclusion by the package and the unit; definitions only.
*/
// Operation
// - Out-of-range voltage, frequency, temperature or light sensor forces chip reset.
// - EEPROM light detector or fault-injection detector raises CPU exception.
// - Reset aborts program; exception interrupts program flow for software.
// - Any chip reset returns all state to defined reset values; the reset cause register keeps its value until por_n.
// - Readable indicator tells which source caused the latest reset.
// - Readable indicator tells why a security exception was raised.
// - Sensors enabled automatically in every CPU mode except test mode.
// - No software write can disable the environmental sensors.
// - Reset-or-exception mapping per source is hard-wired, not configurable.
// - Stack pointer checked against limits; reaching one raises exception.
// - Three stack pointers with own limit checks: user, system, super system.
// - Software picks one of two EEPROM light functions or neither.
// - With inverse error correction enabled, correction errors raise exception.
// - EEPROM high voltage checked each write sequence; result readable only.
// - Every single-bit error in an EEPROM byte corrected by hardware.
// - ROM read parity checked; parity error forces chip reset.
// - PC, SP, status-upper logic and co-processors feed fault detection.
`ifndef SARU_REGS_SVH
`define SARU_REGS_SVH

`define SARU_ADDR_W 8
`define SARU_OFS_CTRL 8'h00
`define SARU_OFS_EXC_STAT 8'h04
`define SARU_OFS_EXC_MASK 8'h08
`define SARU_OFS_RST_CAUSE 8'h0C
`define SARU_OFS_HV_STAT 8'h10
`define SARU_OFS_SENS_STAT 8'h14
`define SARU_OFS_SP_LIM0 8'h18
`define SARU_SP_LIM_STRIDE 8'h04

`define SARU_CTRL_LSEL_LSB 0
`define SARU_CTRL_ECC_EN_BIT 2
`define SARU_CTRL_RESET 3'h0
`define SARU_LSEL_OFF 2'h0
`define SARU_LSEL_FN_A 2'h1
`define SARU_LSEL_FN_B 2'h2

`define SARU_EXC_W 9
`define SARU_EXC_EE_LIGHT 0
`define SARU_EXC_FLT_LSB 1
`define SARU_EXC_ECC 7
`define SARU_EXC_SP_LIM 8
`define SARU_FLT_N 6

`define SARU_RST_W 5
`define SARU_RST_ROM_PAR 4
`define SARU_SENS_N 4

`define SARU_SP_W 16
`define SARU_SP_MODES 3
`define SARU_SP_LO_RESET 16'h0000
`define SARU_SP_HI_RESET 16'hFFFF

`define SARU_PIN_N 13
`define SARU_PIN_SENS_LSB 0
`define SARU_PIN_EEA 4
`define SARU_PIN_EEB 5
`define SARU_PIN_HV 6
`define SARU_PIN_FLT_LSB 7

`define SARU_RST_PULSE_NS 1600
`define SARU_CLK_NS 100
`define SARU_RST_CYC ((`SARU_RST_PULSE_NS + `SARU_CLK_NS - 1) / `SARU_CLK_NS)
`define SARU_RST_CNT_W 5

`endif

// ### src/saru_pkg.sv
/*
 Types of the security alarm response unit: bus request carrier and state.
 Assumes saru_regs.svh on the include path.
*/
`include "saru_regs.svh"
package saru_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [`SARU_ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } saru_apb_req_t;

   typedef struct packed {
      logic [`SARU_SP_W-1:0] hi;
      logic [`SARU_SP_W-1:0] lo;
   } saru_sp_lim_t;

   typedef enum logic [1:0] {SARU_HV_IDLE, SARU_HV_WRITE} saru_hv_st_t;

   typedef struct packed {
      logic [`SARU_PIN_N-1:0] sync1;
      logic [`SARU_PIN_N-1:0] sync2;
      logic [2:0] ctrl;
      logic [`SARU_EXC_W-1:0] exc_stat;
      logic [`SARU_EXC_W-1:0] exc_mask;
      saru_sp_lim_t [`SARU_SP_MODES-1:0] sp_lim;
      saru_hv_st_t hv_st;
      logic hv_run_ok;
      logic hv_ok;
      logic hv_valid;
      logic [`SARU_RST_CNT_W-1:0] rst_cnt;
      logic chip_rst;
      logic cpu_exc;
      logic irq;
      logic sens_en;
      logic [7:0] ee_data;
      logic ee_valid;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } saru_state_t;
endpackage : saru_pkg

// ### src/saru_unit.sv
/*
 Security alarm response unit: collects sensor, fault-injection, stack limit,
 EEPROM and ROM integrity alarms, forces chip reset or raises exceptions,
 records causes, corrects EEPROM bytes; APB register slave.
 Assumes detector pins are asynchronous, CPU and memory signals share clock,
 and chip_rst_o is fed back to rstn by the system reset logic.
 The reset cause register is cleared only by por_n so that it survives
 the reset it reports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "saru_regs.svh"
module saru_unit
   import saru_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic por_n,
   input wire logic ce,
   input wire saru_apb_req_t apb_req,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   input wire logic [`SARU_SENS_N-1:0] sens_alarm,
   input wire logic ee_light_a,
   input wire logic ee_light_b,
   input wire logic ee_hv_ok,
   input wire logic [`SARU_FLT_N-1:0] fault_det,
   input wire logic test_mode,
   input wire logic [1:0] cpu_mode,
   input wire logic [`SARU_SP_W-1:0] sp_user,
   input wire logic [`SARU_SP_W-1:0] sp_sys,
   input wire logic [`SARU_SP_W-1:0] sp_ssm,
   input wire logic ee_wr_seq,
   input wire logic ee_rd_valid,
   input wire logic [11:0] ee_code,
   input wire logic rom_rd_valid,
   input wire logic [7:0] rom_data,
   input wire logic rom_parity,
   output logic [7:0] ee_data,
   output logic ee_data_valid,
   output logic chip_rst_o,
   output logic cpu_exc_o,
   output logic irq_o,
   output logic sensors_en_o
);
   saru_state_t q, d;
   logic [`SARU_RST_W-1:0] cause_q, cause_d;
   logic [`SARU_SP_MODES-1:0] sp_hit;
   logic [`SARU_SP_W-1:0] sp_val [`SARU_SP_MODES];

   assign sp_val[0] = sp_user;
   assign sp_val[1] = sp_sys;
   assign sp_val[2] = sp_ssm;

   // Per-mode limit compare, each pointer against its own pair
   genvar gi;
   generate
      for (gi = 0; gi < `SARU_SP_MODES; gi++) begin : g_sp
         assign sp_hit[gi] = (sp_val[gi] <= q.sp_lim[gi].lo) || (sp_val[gi] >= q.sp_lim[gi].hi);
      end
   endgenerate

   // Hamming(12,8) syndrome, positions 1..12, check bits at 1,2,4,8
   function automatic logic [3:0] syndrome(input logic [11:0] c);
      logic [3:0] s;
      s = 4'h0;
      for (int p = 1; p <= 12; p++) begin
         if (c[p-1]) begin
            s = s ^ 4'(p);
         end
      end
      return s;
   endfunction : syndrome

   function automatic logic [7:0] extract(input logic [11:0] c);
      return {c[11], c[10], c[9], c[8], c[6], c[5], c[4], c[2]};
   endfunction : extract

   logic [3:0] ee_syn;
   logic [11:0] ee_fixed;
   logic [`SARU_EXC_W-1:0] exc_evt;
   logic [`SARU_RST_W-1:0] rst_evt;
   logic ee_light_hit;
   logic sp_fault;
   logic rom_err;
   logic wr_en;
   logic rd_en;
   logic [`SARU_ADDR_W-1:0] addr;
   logic [31:0] rdata;
   logic hit;

   always_comb begin
      ee_syn = syndrome(ee_code);
      ee_fixed = ee_code;
      if (ee_syn != 4'h0 && ee_syn <= 4'hC) begin
         ee_fixed[ee_syn - 4'h1] = ~ee_code[ee_syn - 4'h1];
      end
   end

   always_comb begin
      d = q;
      cause_d = cause_q;
      addr = apb_req.paddr;
      wr_en = apb_req.psel && apb_req.penable && q.pready && apb_req.pwrite;
      rd_en = apb_req.psel && apb_req.penable && !q.pready;

      // Detector pins into two-stage synchronisers
      d.sync1 = {fault_det, ee_hv_ok, ee_light_b, ee_light_a, sens_alarm};
      d.sync2 = q.sync1;

      // Sensors on whenever not in test mode; no register touches this
      d.sens_en = !test_mode;

      // Hard-wired reset class: sensors and ROM parity
      rom_err = rom_rd_valid && ((^rom_data) != rom_parity);
      rst_evt = '0;
      if (q.sens_en) begin
         rst_evt[`SARU_SENS_N-1:0] = q.sync2[`SARU_PIN_SENS_LSB +: `SARU_SENS_N];
      end
      rst_evt[`SARU_RST_ROM_PAR] = rom_err;

      // Hard-wired exception class
      case (q.ctrl[`SARU_CTRL_LSEL_LSB +: 2])
         `SARU_LSEL_FN_A: ee_light_hit = q.sync2[`SARU_PIN_EEA];
         `SARU_LSEL_FN_B: ee_light_hit = q.sync2[`SARU_PIN_EEB];
         default: ee_light_hit = 1'b0;
      endcase
      case (cpu_mode)
         2'h0: sp_fault = sp_hit[0];
         2'h1: sp_fault = sp_hit[1];
         default: sp_fault = sp_hit[2];
      endcase
      exc_evt = '0;
      exc_evt[`SARU_EXC_EE_LIGHT] = ee_light_hit;
      exc_evt[`SARU_EXC_FLT_LSB +: `SARU_FLT_N] = q.sync2[`SARU_PIN_FLT_LSB +: `SARU_FLT_N];
      exc_evt[`SARU_EXC_ECC] = ee_rd_valid && (ee_syn != 4'h0) && q.ctrl[`SARU_CTRL_ECC_EN_BIT];
      exc_evt[`SARU_EXC_SP_LIM] = sp_fault;
      if (|rst_evt) begin
         exc_evt = '0;
      end

      // EEPROM corrected byte out
      d.ee_valid = ee_rd_valid;
      if (ee_rd_valid) begin
         d.ee_data = extract(ee_fixed);
      end

      // High-voltage check over each write sequence, stored only
      case (q.hv_st)
         SARU_HV_IDLE: begin
            if (ee_wr_seq) begin
               d.hv_st = SARU_HV_WRITE;
               d.hv_run_ok = q.sync2[`SARU_PIN_HV];
            end
         end
         SARU_HV_WRITE: begin
            d.hv_run_ok = q.hv_run_ok && q.sync2[`SARU_PIN_HV];
            if (!ee_wr_seq) begin
               d.hv_st = SARU_HV_IDLE;
               d.hv_ok = q.hv_run_ok && q.sync2[`SARU_PIN_HV];
               d.hv_valid = 1'b1;
            end
         end
         default: d.hv_st = SARU_HV_IDLE;
      endcase

      // Reset request: hold for a fixed pulse, record cause
      if (|rst_evt) begin
         d.rst_cnt = `SARU_RST_CNT_W'(`SARU_RST_CYC);
         cause_d = rst_evt;
      end else if (q.rst_cnt != '0) begin
         d.rst_cnt = q.rst_cnt - `SARU_RST_CNT_W'(1);
      end
      d.chip_rst = (|rst_evt) || (q.rst_cnt > `SARU_RST_CNT_W'(1));

      // APB read: data registered in the first access cycle
      hit = 1'b1;
      rdata = 32'h0000_0000;
      case (addr)
         `SARU_OFS_CTRL: rdata = {29'h0, q.ctrl};
         `SARU_OFS_EXC_STAT: rdata = {23'h0, q.exc_stat};
         `SARU_OFS_EXC_MASK: rdata = {23'h0, q.exc_mask};
         `SARU_OFS_RST_CAUSE: rdata = {27'h0, cause_q};
         `SARU_OFS_HV_STAT: rdata = {30'h0, q.hv_valid, q.hv_ok};
         `SARU_OFS_SENS_STAT: rdata = {31'h0, q.sens_en};
         default: begin
            hit = 1'b0;
            for (int m = 0; m < `SARU_SP_MODES; m++) begin
               if (addr == `SARU_OFS_SP_LIM0 + `SARU_ADDR_W'(m) * `SARU_SP_LIM_STRIDE) begin
                  rdata = q.sp_lim[m];
                  hit = 1'b1;
               end
            end
         end
      endcase
      d.pready = rd_en;
      if (rd_en) begin
         d.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
         d.pslverr = !hit;
      end

      // APB write at the completing edge; sensors have no enable field
      d.exc_stat = q.exc_stat;
      if (wr_en && hit) begin
         case (addr)
            `SARU_OFS_CTRL: d.ctrl = apb_req.pwdata[2:0];
            `SARU_OFS_EXC_STAT: d.exc_stat = q.exc_stat & ~apb_req.pwdata[`SARU_EXC_W-1:0];
            `SARU_OFS_EXC_MASK: d.exc_mask = apb_req.pwdata[`SARU_EXC_W-1:0];
            default: begin
               for (int m = 0; m < `SARU_SP_MODES; m++) begin
                  if (addr == `SARU_OFS_SP_LIM0 + `SARU_ADDR_W'(m) * `SARU_SP_LIM_STRIDE) begin
                     d.sp_lim[m] = apb_req.pwdata;
                  end
               end
            end
         endcase
      end
      // Set wins over a same-cycle clear
      d.exc_stat = d.exc_stat | exc_evt;
      d.cpu_exc = |d.exc_stat;
      d.irq = |(d.exc_stat & d.exc_mask);
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         q <= '0;
         q.ctrl <= `SARU_CTRL_RESET;
         q.hv_st <= SARU_HV_IDLE;
         for (int m = 0; m < `SARU_SP_MODES; m++) begin
            q.sp_lim[m].lo <= `SARU_SP_LO_RESET;
            q.sp_lim[m].hi <= `SARU_SP_HI_RESET;
         end
      end else if (ce) begin
         q <= d;
      end
   end

   always_ff @(posedge clock) begin
      if (!por_n) begin
         cause_q <= '0;
      end else if (ce) begin
         cause_q <= cause_d;
      end
   end

   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign prdata = q.prdata;
   assign ee_data = q.ee_data;
   assign ee_data_valid = q.ee_valid;
   assign chip_rst_o = q.chip_rst;
   assign cpu_exc_o = q.cpu_exc;
   assign irq_o = q.irq;
   assign sensors_en_o = q.sens_en;
endmodule : saru_unit
`default_nettype wire

// ### tb/saru_mem_model.sv
/* Memory partner: EEPROM codeword and ROM parity for a data byte.
 Assumes the bench picks the byte and the codeword bit to corrupt. */
`timescale 1ns/1ps
`default_nettype none
module saru_mem_model (
   input wire logic [7:0] data,
   input wire logic [3:0] flip,
   output logic [11:0] code,
   output logic par
);
   logic [11:0] c;
   always_comb begin
      c = 12'h000;
      {c[11:8], c[6:4], c[2]} = data;
      c[0] = c[2] ^ c[4] ^ c[6] ^ c[8] ^ c[10];
      c[1] = c[2] ^ c[5] ^ c[6] ^ c[9] ^ c[10];
      c[3] = c[4] ^ c[5] ^ c[6] ^ c[11];
      c[7] = c[8] ^ c[9] ^ c[10] ^ c[11];
      // Flip 0 leaves the word clean
      code = (flip == 4'h0) ? c : c ^ (12'h001 << (flip - 4'h1));
      par = ^data;
   end
endmodule : saru_mem_model
`default_nettype wire

// ### tb/saru_unit_sva.sv
/* Port checker of the alarm unit, bound into saru_unit.
 Assumes one clock and rstn synchronous, active low. */
`timescale 1ns/1ps
`default_nettype none
module saru_unit_sva
   import saru_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   input wire saru_apb_req_t apb_req,
   input wire logic pready,
   input wire logic [3:0] sens_alarm,
   input wire logic [5:0] fault_det,
   input wire logic test_mode,
   input wire logic rom_rd_valid,
   input wire logic [7:0] rom_data,
   input wire logic rom_parity,
   input wire logic chip_rst_o,
   input wire logic cpu_exc_o,
   input wire logic irq_o,
   input wire logic sensors_en_o
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_acc; ce && apb_req.psel && apb_req.penable && !pready; endsequence
   sequence s_sens; ce && !test_mode && |sens_alarm; endsequence
   sequence s_flt; ce && |fault_det && !(|sens_alarm) && !rom_rd_valid; endsequence
   apb_wait_a: assert property (s_acc |=> pready ##1 !pready) else $error("apb answer");
   sens_rst_a: assert property (s_sens [*3] |=> chip_rst_o) else $error("sensor reset");
   rst_hold_a: assert property ($rose(chip_rst_o) |=> chip_rst_o [*8]) else $error("reset short");
   rom_rst_a: assert property (ce && rom_rd_valid && (^rom_data != rom_parity) |=> chip_rst_o)
      else $error("parity reset");
   flt_exc_a: assert property (s_flt [*4] |=> cpu_exc_o) else $error("fault exception");
   irq_exc_a: assert property (irq_o |-> cpu_exc_o) else $error("irq alone");
   sens_en_a: assert property ($past(rstn) && $past(ce) |-> sensors_en_o == !$past(test_mode))
      else $error("sensor enable");
   rst_clr_a: assert property ($rose(rstn) |-> !(chip_rst_o | cpu_exc_o | irq_o | pready | sensors_en_o))
      else $error("reset outputs");
endmodule : saru_unit_sva
bind saru_unit saru_unit_sva saru_unit_sva_inst (.clock, .rstn, .ce, .apb_req, .pready, .sens_alarm, .fault_det,
   .test_mode, .rom_rd_valid, .rom_data, .rom_parity, .chip_rst_o, .cpu_exc_o, .irq_o, .sensors_en_o);
`default_nettype wire

// ### tb/tb.sv
/* Self-checking bench of the alarm unit.
 Assumes package, memory partner and bound checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import saru_pkg::*;
   logic clock = 1'b0, rstn = 1'b0, por_n = 1'b0, ce = 1'b1, err, par, pready, pslverr, ee_data_valid;
   logic chip_rst_o, cpu_exc_o, irq_o, sensors_en_o, ee_light_a = 1'b0, ee_light_b = 1'b0, ee_hv_ok = 1'b1;
   logic test_mode = 1'b0, ee_wr_seq = 1'b0, ee_rd_valid = 1'b0, rom_rd_valid = 1'b0, rom_parity = 1'b0;
   logic [3:0] sens_alarm = 4'h0, flip = 4'h0;
   logic [5:0] fault_det = 6'h00;
   logic [1:0] cpu_mode = 2'h0;
   logic [15:0] sp_user = 16'h8000, sp_sys = 16'h8000, sp_ssm = 16'h8000, lo, hi, v;
   logic [7:0] d = 8'h00, ee_data;
   logic [11:0] ee_code;
   logic [31:0] prdata, rd, m;
   saru_apb_req_t req = '0;
   int num_errors = 0, checked = 0;
   always #50 clock = ~clock;
   saru_unit saru_unit_inst (.clock, .rstn, .por_n, .ce, .apb_req(req), .pready, .pslverr, .prdata,
      .sens_alarm, .ee_light_a, .ee_light_b, .ee_hv_ok, .fault_det, .test_mode, .cpu_mode, .sp_user,
      .sp_sys, .sp_ssm, .ee_wr_seq, .ee_rd_valid, .ee_code, .rom_rd_valid, .rom_data(d), .rom_parity,
      .ee_data, .ee_data_valid, .chip_rst_o, .cpu_exc_o, .irq_o, .sensors_en_o);
   saru_mem_model saru_mem_model_inst (.data(d), .flip, .code(ee_code), .par);
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc
   // Register value right after reset, by word index
   function automatic logic [31:0] rst_val(input int i);
      if (i == 5) return 32'h0000_0001;
      else if (i > 5) return {16'hFFFF, 16'h0000};
      else return 32'h0000_0000;
   endfunction : rst_val
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   task automatic chkb(input string w, input logic e, input logic g);
      chk(w, {31'h0, e}, {31'h0, g});
   endtask : chkb
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      req <= '{1'b1, 1'b0, wr, a, wd};
      @(posedge clock);
      req.penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      chkb("pready", 1'b1, pready);
      req <= '0;
      @(posedge clock);
   endtask : apb
   task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(w, e, rd);
   endtask : rdc
   task automatic do_reset;
      rstn <= 1'b0;
      cyc(3);
      rstn <= 1'b1;
      cyc(1);
   endtask : do_reset
   task automatic finish_test;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   initial begin
      repeat (30000) @(posedge clock);
      num_errors++;
      finish_test();
   end
   initial begin
      void'($urandom(9475));
      do_reset();
      por_n <= 1'b1;
      for (int i = 0; i < 9; i++)
         rdc("reset", 8'(4 * i), rst_val(i));
      apb(1'b0, 8'h40, 32'h0);
      chkb("unmapped", 1'b1, err);
      apb(1'b1, 8'h14, 32'h0);
      rdc("sensors on", 8'h14, 32'h1);
      $display("registers done");
      m = $urandom;
      apb(1'b1, 8'h08, m);
      for (int i = 0; i < 6; i++) begin
         fault_det <= 6'h01 << i;
         cyc(4);
         fault_det <= 6'h00;
         cyc(1);
         chkb("exception", 1'b1, cpu_exc_o);
         chkb("irq", m[i + 1], irq_o);
         rdc("fault", 8'h04, 32'h2 << i);
         apb(1'b1, 8'h04, 32'h2 << i);
         rdc("cleared", 8'h04, 32'h0);
         chkb("exception off", 1'b0, cpu_exc_o);
      end
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, 8'h00, 32'(s));
         for (int f = 0; f < 2; f++) begin
            {ee_light_b, ee_light_a} <= 2'h1 << f;
            cyc(4);
            {ee_light_b, ee_light_a} <= 2'h0;
            rdc("light", 8'h04, {31'h0, s == f + 1});
            apb(1'b1, 8'h04, 32'h1);
         end
      end
      $display("exceptions done");
      test_mode <= 1'b1;
      sens_alarm <= 4'hF;
      cyc(6);
      chkb("test mode", 1'b0, chip_rst_o);
      chkb("sensor pin off", 1'b0, sensors_en_o);
      rdc("sensors off", 8'h14, 32'h0);
      sens_alarm <= 4'h0;
      cyc(3);
      test_mode <= 1'b0;
      cyc(2);
      chkb("sensor pin on", 1'b1, sensors_en_o);
      for (int i = 0; i < 5; i++) begin
         sens_alarm <= (i < 4) ? 4'h1 << i : 4'h0;
         fault_det <= (i < 4) ? 6'h01 : 6'h00;
         rom_rd_valid <= (i == 4);
         rom_parity <= ~par;
         cyc(1);
         rom_rd_valid <= 1'b0;
         cyc(2);
         sens_alarm <= 4'h0;
         fault_det <= 6'h00;
         cyc(1);
         chkb("reset on", 1'b1, chip_rst_o);
         cyc(20);
         chkb("reset off", 1'b0, chip_rst_o);
         rdc("cause", 8'h0C, 32'h1 << i);
         rdc("no exception", 8'h04, 32'h0);
         do_reset();
         rdc("cause kept", 8'h0C, 32'h1 << i);
      end
      $display("resets done");
      lo = 16'($urandom_range(32'h7F00, 32'h0100));
      hi = lo + 16'h0100;
      // Pointers inside the new window before it is written, else 8000 sits at or above hi
      {sp_user, sp_sys, sp_ssm} <= {3{lo + 16'h1}};
      for (int k = 0; k < 3; k++)
         apb(1'b1, 8'(24 + 4 * k), {hi, lo});
      rdc("limit", 8'h20, {hi, lo});
      for (int k = 0; k < 4; k++) begin
         cpu_mode <= 2'(k);
         v = $urandom_range(1, 0) ? hi : lo;
         cyc(2);
         rdc("in range", 8'h04, 32'h0);
         if (k == 0) sp_user <= v;
         else if (k == 1) sp_sys <= v;
         else sp_ssm <= v;
         cyc(2);
         rdc("at limit", 8'h04, 32'h100);
         {sp_user, sp_sys, sp_ssm} <= {3{lo + 16'h1}};
         cyc(1);
         apb(1'b1, 8'h04, 32'h100);
      end
      for (int k = 0; k < 26; k++) begin
         d <= 8'($urandom);
         flip <= 4'(k % 13);
         apb(1'b1, 8'h00, (k > 12) ? 32'h4 : 32'h0);
         {ee_rd_valid, rom_rd_valid, rom_parity} <= {2'h3, par};
         cyc(1);
         {ee_rd_valid, rom_rd_valid} <= 2'h0;
         cyc(1);
         chkb("data valid", 1'b1, ee_data_valid);
         chk("corrected", {24'h0, d}, {24'h0, ee_data});
         chkb("good parity", 1'b0, chip_rst_o);
         rdc("ecc", 8'h04, (k > 13) ? 32'h80 : 32'h0);
         apb(1'b1, 8'h04, 32'h80);
      end
      for (int h = 0; h < 2; h++) begin
         ee_wr_seq <= 1'b1;
         cyc(3);
         ee_hv_ok <= h[0];
         cyc(1);
         ee_hv_ok <= 1'b1;
         cyc(4);
         ee_wr_seq <= 1'b0;
         cyc(2);
         rdc("hv", 8'h10, {30'h0, 1'b1, h[0]});
         chkb("hv quiet", 1'b0, cpu_exc_o | chip_rst_o);
      end
      $display("memory done");
      finish_test();
   end
endmodule : tb
`default_nettype wire
